//--- design/mdb_brake_seq.sv
// What this block does
// - Mains on with no fault standing closes interlock and fault relay
// - Powering up with motor off never brakes
// - Motor voltage drop starts braking sequence
// - Interlock path open throughout braking
// - Star contactor path closed throughout braking
// - Adaptive remanence delay, relay, bounce, then current
// - Current setpoint from trim, ten to hundred percent
// - Standstill ends current after 1.5 s
// - Standstill threshold from separate trim
// - No third phase: blank standstill first 1.5 s
// - Break contact or voltage drop triggers braking
// - No break contact: remanence may stretch half
// - No break contact: interlock opens before relay
// - Ready lit steady with mains, no fault
// - Ready flashes fault code bursts with pause
// - Current indicator lit while current flows
// - Fault relay closed only with supply, no fault
// - Motor restart clears standstill, current faults
// - Lockout faults clear after 5 s mains loss
// - Threshold below twenty percent: brake full time
//
// The register offsets and the APB slave port are this design's own decisions.
module mdb_brake_seq #(
  parameter logic [31:0] HOLD_CYC      = mdb_pkg::HOLD_CYC,
  parameter logic [31:0] BLANK_CYC     = mdb_pkg::BLANK_CYC,
  parameter logic [31:0] MAX_BRAKE_CYC = mdb_pkg::MAX_BRAKE_CYC,
  parameter logic [31:0] REM_MIN_CYC   = mdb_pkg::REM_MIN_CYC,
  parameter logic [31:0] REM_MAX_CYC   = mdb_pkg::REM_MAX_CYC,
  parameter logic [31:0] REM_EXT_CYC   = mdb_pkg::REM_EXT_CYC,
  parameter logic [31:0] BOUNCE_CYC    = mdb_pkg::BOUNCE_CYC,
  parameter logic [31:0] LEAD_CYC      = mdb_pkg::LEAD_CYC,
  parameter logic [31:0] CUR_CHECK_CYC = mdb_pkg::CUR_CHECK_CYC,
  parameter logic [31:0] MIN_GAP_CYC   = mdb_pkg::MIN_GAP_CYC,
  parameter logic [31:0] MAINS_OFF_CYC = mdb_pkg::MAINS_OFF_CYC,
  parameter logic [31:0] FLASH_ON_CYC  = mdb_pkg::FLASH_ON_CYC,
  parameter logic [31:0] FLASH_OFF_CYC = mdb_pkg::FLASH_OFF_CYC,
  parameter logic [31:0] PAUSE_CYC     = mdb_pkg::PAUSE_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mainsPresent,
  input  wire logic        motorVoltagePresent,
  input  wire logic        startContactWired,
  input  wire logic        startContactClosed,
  input  wire logic        thirdPhaseConnected,
  input  wire logic        remanenceLow,
  input  wire logic [6:0]  standstillLevel,
  input  wire logic        currentReached,
  output logic             interlockClosed,
  output logic             starContactorClosed,
  output logic             brakeRelayClosed,
  output logic             brakeCurrentEnable,
  output logic      [6:0]  brakeCurrentSetpoint,
  output logic             readyIndicator,
  output logic             currentIndicator,
  output logic             faultRelayClosed
);

  typedef struct packed {
    mdb_pkg::mdb_state_type st;
    logic [31:0]            stTmr;
    logic [31:0]            brkTmr;
    logic [31:0]            gapTmr;
    logic                   gapRun;
    logic [31:0]            offTmr;
    logic                   fNoStand;
    logic                   fCur;
    logic                   fFreq;
    logic                   fLock;
    logic [1:0]             consec;
    logic                   curSeen;
    logic                   ssMissed;
    logic                   viaContact;
    logic [6:0]             curTrim;
    logic [6:0]             ssTrim;
    logic [31:0]            rdata;
    logic                   slvErr;
    logic                   interlock;
    logic                   star;
    logic                   relay;
    logic                   curEn;
    logic [6:0]             setpoint;
    logic                   faultRelay;
  } mdb_seq_type;

  mdb_seq_type q_ff;
  mdb_seq_type nxt_q;
  logic [2:0]  faultCode;

  function automatic logic [6:0] clampPct(input logic [6:0] v, input logic [6:0] lo);
    logic [6:0] r;
    r = v;
    if (r < lo) begin
      r = lo;
    end
    if (r > mdb_pkg::PCT_MAX) begin
      r = mdb_pkg::PCT_MAX;
    end
    return r;
  endfunction : clampPct

  always_comb begin
    logic        held;
    logic        trigger;
    logic        standstill;
    logic [31:0] remMax;
    logic        setup;
    nxt_q      = q_ff;
    held       = q_ff.fFreq | q_ff.fLock;
    trigger    = 1'b0;
    standstill = 1'b0;
    remMax     = REM_MAX_CYC;
    setup      = psel & ~penable;
    nxt_q.stTmr  = q_ff.stTmr + 32'h1;
    nxt_q.offTmr = '0;
    if (q_ff.gapRun && q_ff.gapTmr < MIN_GAP_CYC) begin
      nxt_q.gapTmr = q_ff.gapTmr + 32'h1;
    end

    // Register bus: write at access, read data captured at setup
    nxt_q.slvErr = 1'b0;
    if (setup) begin
      nxt_q.rdata = '0;
      case (paddr)
        mdb_pkg::CTRL_OFFSET: begin
          nxt_q.rdata[mdb_pkg::CTRL_CUR_LSB +: 7] = q_ff.curTrim;
          nxt_q.rdata[mdb_pkg::CTRL_SS_LSB +: 7]  = q_ff.ssTrim;
        end
        mdb_pkg::STATUS_OFFSET: begin
          nxt_q.rdata[mdb_pkg::STAT_STATE_LSB +: 4] = q_ff.st;
          nxt_q.rdata[mdb_pkg::STAT_FAULT_LSB +: 4] =
            {q_ff.fLock, q_ff.fFreq, q_ff.fCur, q_ff.fNoStand};
          nxt_q.rdata[mdb_pkg::STAT_CONS_LSB +: 2] = q_ff.consec;
          nxt_q.rdata[mdb_pkg::STAT_OUT_LSB +: 4] =
            {q_ff.curEn, q_ff.relay, q_ff.star, q_ff.interlock};
        end
        default: begin
          nxt_q.slvErr = 1'b1;
        end
      endcase
    end
    if (psel && penable && pwrite && paddr == mdb_pkg::CTRL_OFFSET) begin
      nxt_q.curTrim = pwdata[mdb_pkg::CTRL_CUR_LSB +: 7];
      nxt_q.ssTrim  = pwdata[mdb_pkg::CTRL_SS_LSB +: 7];
    end
    nxt_q.setpoint = clampPct(q_ff.curTrim, mdb_pkg::CUR_MIN_PCT);

    if (q_ff.ssTrim >= mdb_pkg::SS_ENABLE_PCT &&
        standstillLevel < clampPct(q_ff.ssTrim, 7'h00)) begin
      standstill = 1'b1;
    end
    // Blanked early; a stop seen there runs full time
    if (!thirdPhaseConnected && q_ff.brkTmr < BLANK_CYC) begin
      nxt_q.ssMissed = q_ff.ssMissed | standstill;
      standstill     = 1'b0;
    end
    standstill = standstill & ~q_ff.ssMissed;
    trigger = ~motorVoltagePresent | (startContactWired & startContactClosed);
    if (!q_ff.viaContact) begin
      remMax = REM_EXT_CYC;
    end

    if (!mainsPresent) begin
      // Without supply every contact drops open
      nxt_q.st         = mdb_pkg::MDB_POWERUP;
      nxt_q.interlock  = 1'b0;
      nxt_q.star       = 1'b0;
      nxt_q.relay      = 1'b0;
      nxt_q.curEn      = 1'b0;
      nxt_q.offTmr     = q_ff.offTmr;
      if (q_ff.offTmr >= MAINS_OFF_CYC - 32'h1) begin
        nxt_q.fFreq  = 1'b0;
        nxt_q.fLock  = 1'b0;
        nxt_q.consec = '0;
      end else begin
        nxt_q.offTmr = q_ff.offTmr + 32'h1;
      end
    end else begin
      case (q_ff.st)
        mdb_pkg::MDB_POWERUP: begin
          nxt_q.st        = mdb_pkg::MDB_STANDBY;
          nxt_q.interlock = ~held;
          nxt_q.star      = held;
        end
        mdb_pkg::MDB_STANDBY: begin
          if (motorVoltagePresent) begin
            nxt_q.st = mdb_pkg::MDB_RUNNING;
            nxt_q.fNoStand = 1'b0;
            nxt_q.fCur     = 1'b0;
          end
        end
        mdb_pkg::MDB_RUNNING: begin
          if (trigger) begin
            nxt_q.st         = mdb_pkg::MDB_REMANENCE;
            nxt_q.stTmr      = '0;
            nxt_q.viaContact = startContactWired;
            if (q_ff.gapRun && q_ff.gapTmr < MIN_GAP_CYC) begin
              nxt_q.fFreq = 1'b1;
            end
            if (startContactWired) begin
              nxt_q.interlock = 1'b0;
              nxt_q.star      = 1'b1;
            end
          end
        end
        mdb_pkg::MDB_REMANENCE: begin
          if (!q_ff.viaContact && motorVoltagePresent) begin
            nxt_q.st = mdb_pkg::MDB_RUNNING;
          end else if ((q_ff.stTmr >= REM_MIN_CYC - 32'h1 && remanenceLow) ||
                       q_ff.stTmr >= remMax - 32'h1) begin
            nxt_q.st        = mdb_pkg::MDB_PREP;
            nxt_q.stTmr     = '0;
            nxt_q.interlock = 1'b0;
            nxt_q.star      = 1'b1;
          end
        end
        mdb_pkg::MDB_PREP: begin
          if (q_ff.stTmr >= LEAD_CYC - 32'h1) begin
            nxt_q.st    = mdb_pkg::MDB_BOUNCE;
            nxt_q.stTmr = '0;
            nxt_q.relay = 1'b1;
          end
        end
        mdb_pkg::MDB_BOUNCE: begin
          if (q_ff.stTmr >= BOUNCE_CYC - 32'h1) begin
            nxt_q.st      = mdb_pkg::MDB_BRAKING;
            nxt_q.curEn   = 1'b1;
            nxt_q.brkTmr  = '0;
            nxt_q.curSeen = 1'b0;
            nxt_q.ssMissed = 1'b0;
          end
        end
        mdb_pkg::MDB_BRAKING, mdb_pkg::MDB_HOLD: begin
          nxt_q.brkTmr = q_ff.brkTmr + 32'h1;
          if (currentReached) begin
            nxt_q.curSeen = 1'b1;
          end
          if (q_ff.brkTmr == CUR_CHECK_CYC - 32'h1 && !q_ff.curSeen && !currentReached) begin
            nxt_q.fCur = 1'b1;
          end
          if (q_ff.st == mdb_pkg::MDB_HOLD) begin
            if (q_ff.stTmr >= HOLD_CYC - 32'h1) begin
              nxt_q.st     = mdb_pkg::MDB_RELEASE;
              nxt_q.stTmr  = '0;
              nxt_q.curEn  = 1'b0;
              nxt_q.consec = '0;
            end
          end else if (q_ff.brkTmr >= MAX_BRAKE_CYC - 32'h1) begin
            nxt_q.st       = mdb_pkg::MDB_RELEASE;
            nxt_q.stTmr    = '0;
            nxt_q.curEn    = 1'b0;
            nxt_q.fNoStand = 1'b1;
            if (q_ff.consec == mdb_pkg::LOCKOUT_COUNT) begin
              nxt_q.fLock  = 1'b1;
              nxt_q.consec = '0;
            end else begin
              nxt_q.consec = q_ff.consec + 2'h1;
            end
          end else if (standstill) begin
            nxt_q.st    = mdb_pkg::MDB_HOLD;
            nxt_q.stTmr = '0;
          end
        end
        mdb_pkg::MDB_RELEASE: begin
          if (q_ff.stTmr == LEAD_CYC - 32'h1) begin
            nxt_q.relay = 1'b0;
          end
          if (q_ff.stTmr >= LEAD_CYC + LEAD_CYC - 32'h1) begin
            nxt_q.st        = mdb_pkg::MDB_STANDBY;
            nxt_q.interlock = ~(nxt_q.fFreq | nxt_q.fLock);
            nxt_q.star      = nxt_q.fFreq | nxt_q.fLock;
            nxt_q.gapRun    = 1'b1;
            nxt_q.gapTmr    = '0;
          end
        end
        default: begin
          nxt_q.st = mdb_pkg::MDB_POWERUP;
        end
      endcase
    end
    // Fault relay from supply and faults
    nxt_q.faultRelay = mainsPresent &
      ~(nxt_q.fNoStand | nxt_q.fCur | nxt_q.fFreq | nxt_q.fLock);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q_ff          <= '0;
      q_ff.st       <= mdb_pkg::MDB_POWERUP;
      q_ff.curTrim  <= mdb_pkg::CUR_TRIM_RST;
      q_ff.ssTrim   <= mdb_pkg::SS_TRIM_RST;
      q_ff.setpoint <= mdb_pkg::CUR_TRIM_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  always_comb begin
    faultCode = mdb_pkg::CODE_NONE;
    if (q_ff.fLock) begin
      faultCode = mdb_pkg::CODE_LOCKOUT;
    end else if (q_ff.fFreq) begin
      faultCode = mdb_pkg::CODE_FREQ;
    end else if (q_ff.fCur) begin
      faultCode = mdb_pkg::CODE_CURRENT;
    end else if (q_ff.fNoStand) begin
      faultCode = mdb_pkg::CODE_NOSTAND;
    end
  end

  mdb_flash_code #(
    .ON_CYC    (FLASH_ON_CYC),
    .OFF_CYC   (FLASH_OFF_CYC),
    .PAUSE_CYC (PAUSE_CYC)
  ) uFlash (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .enable  (mainsPresent),
    .code    (faultCode),
    .led     (readyIndicator)
  );

  assign pready               = 1'b1;
  assign prdata               = q_ff.rdata;
  assign pslverr              = q_ff.slvErr & psel & penable;
  assign interlockClosed      = q_ff.interlock;
  assign starContactorClosed  = q_ff.star;
  assign brakeRelayClosed     = q_ff.relay;
  assign brakeCurrentEnable   = q_ff.curEn;
  assign brakeCurrentSetpoint = q_ff.setpoint;
  assign currentIndicator     = q_ff.curEn;
  assign faultRelayClosed     = q_ff.faultRelay;

endmodule : mdb_brake_seq

//--- design/mdb_pkg.sv
package mdb_pkg;

  // Controller clock
  localparam longint unsigned CLK_HZ = 64'd50_000_000;

  // Timing figures in milliseconds
  localparam longint unsigned HOLD_MS      = 64'd1500;
  localparam longint unsigned BLANK_MS     = 64'd1500;
  localparam longint unsigned MAX_BRAKE_MS = 64'd12000;
  localparam longint unsigned REM_MIN_MS   = 64'd200;
  localparam longint unsigned REM_MAX_MS   = 64'd2000;
  localparam longint unsigned REM_EXT_MS   = 64'd3000;
  localparam longint unsigned BOUNCE_MS    = 64'd20;
  localparam longint unsigned LEAD_MS      = 64'd20;
  localparam longint unsigned CUR_CHECK_MS = 64'd500;
  localparam longint unsigned MIN_GAP_MS   = 64'd10000;
  localparam longint unsigned MAINS_OFF_MS = 64'd5000;
  localparam longint unsigned FLASH_ON_MS  = 64'd200;
  localparam longint unsigned FLASH_OFF_MS = 64'd300;
  localparam longint unsigned PAUSE_MS     = 64'd1500;

  // Cycle counts, rounded up, at least one cycle
  function automatic logic [31:0] msToCyc(input longint unsigned ms);
    longint unsigned c;
    c = (ms * CLK_HZ + 64'd999) / 64'd1000;
    if (c == 64'd0) begin
      c = 64'd1;
    end
    return c[31:0];
  endfunction : msToCyc

  localparam logic [31:0] HOLD_CYC      = msToCyc(HOLD_MS);
  localparam logic [31:0] BLANK_CYC     = msToCyc(BLANK_MS);
  localparam logic [31:0] MAX_BRAKE_CYC = msToCyc(MAX_BRAKE_MS);
  localparam logic [31:0] REM_MIN_CYC   = msToCyc(REM_MIN_MS);
  localparam logic [31:0] REM_MAX_CYC   = msToCyc(REM_MAX_MS);
  localparam logic [31:0] REM_EXT_CYC   = msToCyc(REM_EXT_MS);
  localparam logic [31:0] BOUNCE_CYC    = msToCyc(BOUNCE_MS);
  localparam logic [31:0] LEAD_CYC      = msToCyc(LEAD_MS);
  localparam logic [31:0] CUR_CHECK_CYC = msToCyc(CUR_CHECK_MS);
  localparam logic [31:0] MIN_GAP_CYC   = msToCyc(MIN_GAP_MS);
  localparam logic [31:0] MAINS_OFF_CYC = msToCyc(MAINS_OFF_MS);
  localparam logic [31:0] FLASH_ON_CYC  = msToCyc(FLASH_ON_MS);
  localparam logic [31:0] FLASH_OFF_CYC = msToCyc(FLASH_OFF_MS);
  localparam logic [31:0] PAUSE_CYC     = msToCyc(PAUSE_MS);

  // Setting limits in percent
  localparam logic [6:0] CUR_MIN_PCT   = 7'h0A;
  localparam logic [6:0] PCT_MAX       = 7'h64;
  localparam logic [6:0] SS_ENABLE_PCT = 7'h14;

  // Register map
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam int          CTRL_CUR_LSB  = 0;
  localparam int          CTRL_SS_LSB   = 8;
  localparam logic [6:0]  CUR_TRIM_RST  = 7'h32;
  localparam logic [6:0]  SS_TRIM_RST   = 7'h28;
  localparam int          STAT_STATE_LSB = 0;
  localparam int          STAT_FAULT_LSB = 4;
  localparam int          STAT_CONS_LSB  = 8;
  localparam int          STAT_OUT_LSB   = 12;

  // Flash codes
  localparam logic [2:0] CODE_NONE     = 3'h0;
  localparam logic [2:0] CODE_NOSTAND  = 3'h1;
  localparam logic [2:0] CODE_CURRENT  = 3'h2;
  localparam logic [2:0] CODE_FREQ     = 3'h3;
  localparam logic [2:0] CODE_LOCKOUT  = 3'h5;
  localparam logic [1:0] LOCKOUT_COUNT = 2'h2;

  typedef enum logic [3:0] {
    MDB_POWERUP, MDB_STANDBY, MDB_RUNNING, MDB_REMANENCE, MDB_PREP,
    MDB_BOUNCE, MDB_BRAKING, MDB_HOLD, MDB_RELEASE
  } mdb_state_type;

endpackage : mdb_pkg

//--- design/mdb_flash_code.sv
module mdb_flash_code #(
  parameter logic [31:0] ON_CYC    = mdb_pkg::FLASH_ON_CYC,
  parameter logic [31:0] OFF_CYC   = mdb_pkg::FLASH_OFF_CYC,
  parameter logic [31:0] PAUSE_CYC = mdb_pkg::PAUSE_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       enable,
  input  wire logic [2:0] code,
  output logic            led
);

  typedef struct packed {
    logic [31:0] tmr;
    logic [2:0]  cnt;
    logic        lit;
    logic        pause;
    logic        led;
  } mdb_flash_type;

  mdb_flash_type q_ff;
  mdb_flash_type nxt_q;

  always_comb begin
    nxt_q     = q_ff;
    nxt_q.tmr = q_ff.tmr + 32'h1;
    if (!enable || code == mdb_pkg::CODE_NONE) begin
      // Steady light while healthy, dark without mains
      nxt_q     = '0;
      nxt_q.led = enable;
    end else if (q_ff.pause) begin
      if (q_ff.tmr >= PAUSE_CYC - 32'h1) begin
        nxt_q.pause = 1'b0;
        nxt_q.lit   = 1'b1;
        nxt_q.tmr   = '0;
        nxt_q.cnt   = '0;
      end
    end else if (q_ff.lit) begin
      if (q_ff.tmr >= ON_CYC - 32'h1) begin
        nxt_q.lit = 1'b0;
        nxt_q.tmr = '0;
        nxt_q.cnt = q_ff.cnt + 3'h1;
      end
    end else if (q_ff.tmr >= OFF_CYC - 32'h1) begin
      nxt_q.tmr = '0;
      if (q_ff.cnt >= code) begin
        nxt_q.pause = 1'b1;
      end else begin
        nxt_q.lit = 1'b1;
      end
    end
    if (enable && code != mdb_pkg::CODE_NONE) begin
      nxt_q.led = nxt_q.lit;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign led = q_ff.led;

endmodule : mdb_flash_code

//--- tb/mdb_brake_seq_sva.sv
module mdb_brake_seq_sva (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       mainsPresent,
  input wire logic       startContactWired,
  input wire logic       interlockClosed,
  input wire logic       starContactorClosed,
  input wire logic       brakeRelayClosed,
  input wire logic       brakeCurrentEnable,
  input wire logic [6:0] brakeCurrentSetpoint,
  input wire logic       readyIndicator,
  input wire logic       currentIndicator,
  input wire logic       faultRelayClosed
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_curOff;
    mainsPresent && $fell(brakeCurrentEnable);
  endsequence
  sequence s_relayLag;
    brakeRelayClosed [*3] ##1 !brakeRelayClosed;
  endsequence
  sequence s_leadWait;
    !brakeRelayClosed [*3] ##1 brakeRelayClosed;
  endsequence

  a_current_lamp: assert property (currentIndicator == brakeCurrentEnable)
    else $error("current lamp differs from current enable");
  a_interlock_open: assert property (brakeCurrentEnable |-> !interlockClosed)
    else $error("interlock closed while braking");
  a_star_closed: assert property (brakeCurrentEnable |-> starContactorClosed)
    else $error("star path open while braking");
  a_bounce_wait: assert property ($rose(brakeCurrentEnable) |->
    $past(brakeRelayClosed, 3) && !$past(brakeRelayClosed, 4))
    else $error("current not three cycles after relay");
  a_setpoint_span: assert property (brakeCurrentSetpoint inside {[7'h0A:7'h64]})
    else $error("setpoint outside span");
  a_release_order: assert property (disable iff (!resetn || !mainsPresent)
    s_curOff |-> s_relayLag)
    else $error("relay did not open after lead");
  a_lead_relay: assert property (disable iff (!resetn || !mainsPresent)
    !startContactWired && $fell(interlockClosed) |-> s_leadWait)
    else $error("interlock opened too early");
  a_mains_off: assert property (!mainsPresent [*3] |->
    !faultRelayClosed && !interlockClosed && !starContactorClosed)
    else $error("contacts closed without mains");
  a_ready_steady: assert property (faultRelayClosed [*3] |-> readyIndicator)
    else $error("ready dark without fault");
endmodule : mdb_brake_seq_sva

bind mdb_brake_seq mdb_brake_seq_sva u_sva (.ref_clk(ref_clk), .resetn(resetn),
  .mainsPresent(mainsPresent), .startContactWired(startContactWired),
  .interlockClosed(interlockClosed), .starContactorClosed(starContactorClosed),
  .brakeRelayClosed(brakeRelayClosed), .brakeCurrentEnable(brakeCurrentEnable),
  .brakeCurrentSetpoint(brakeCurrentSetpoint), .readyIndicator(readyIndicator),
  .currentIndicator(currentIndicator), .faultRelayClosed(faultRelayClosed));

//--- tb/mdb_motor_model.sv
module mdb_motor_model (
  input  wire logic       ref_clk,
  input  wire logic       runCmd,
  input  wire logic       interlockClosed,
  input  wire logic       brakeCurrentEnable,
  input  wire logic       goodCurrent,
  input  wire logic [6:0] stopRate,
  input  wire logic [7:0] remHold,
  output logic            motorVoltagePresent,
  output logic            startContactClosed,
  output logic            remanenceLow,
  output logic      [6:0] standstillLevel,
  output logic            currentReached
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] remCnt = 8'h00;
  logic [6:0] speed = 7'h00;
  initial motorVoltagePresent = 1'b0;
  // Contactor only pulls in through the interlock path
  always @(posedge ref_clk) begin
    motorVoltagePresent <= runCmd && interlockClosed;
    remCnt <= motorVoltagePresent ? 8'h00 : remCnt + {7'h00, remCnt != 8'hFF};
    if (motorVoltagePresent) begin
      speed <= 7'h64;
    end else if (brakeCurrentEnable) begin
      speed <= (speed > stopRate) ? speed - stopRate : 7'h00;
    end
  end
  assign startContactClosed = !motorVoltagePresent;
  assign remanenceLow       = remCnt >= remHold;
  assign standstillLevel    = speed;
  assign currentReached     = brakeCurrentEnable && goodCurrent;
endmodule : mdb_motor_model

//--- tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, errSeen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic mainsPresent, motorVoltagePresent, startContactWired, startContactClosed;
  logic thirdPhaseConnected, remanenceLow, currentReached, runCmd, goodCurrent;
  logic [6:0] standstillLevel, stopRate, brakeCurrentSetpoint;
  logic [7:0] remHold;
  logic interlockClosed, starContactorClosed, brakeRelayClosed, brakeCurrentEnable;
  logic readyIndicator, currentIndicator, faultRelayClosed;
  int error_cnt = 0;
  int samples_checked = 0;
  int curCyc;
  localparam int LEAD_T = 3, FLASH_T = 4, CHECK_T = 10, PHASE_T = 20;
  wire logic [1:0] obs = {brakeCurrentEnable, brakeRelayClosed};

  mdb_brake_seq #(.HOLD_CYC(PHASE_T), .BLANK_CYC(PHASE_T), .MAX_BRAKE_CYC(100), .REM_MIN_CYC(5),
    .REM_MAX_CYC(PHASE_T), .REM_EXT_CYC(30), .BOUNCE_CYC(LEAD_T), .LEAD_CYC(LEAD_T),
    .CUR_CHECK_CYC(CHECK_T), .MIN_GAP_CYC(50), .MAINS_OFF_CYC(30), .FLASH_ON_CYC(FLASH_T),
    .FLASH_OFF_CYC(FLASH_T), .PAUSE_CYC(CHECK_T)) dut (.ref_clk, .resetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mainsPresent,
    .motorVoltagePresent, .startContactWired,
    .startContactClosed, .thirdPhaseConnected, .remanenceLow, .standstillLevel,
    .currentReached, .interlockClosed, .starContactorClosed, .brakeRelayClosed,
    .brakeCurrentEnable, .brakeCurrentSetpoint, .readyIndicator, .currentIndicator,
    .faultRelayClosed);
  mdb_motor_model model (.ref_clk, .runCmd, .interlockClosed, .brakeCurrentEnable,
    .goodCurrent, .stopRate, .remHold, .motorVoltagePresent, .startContactClosed,
    .remanenceLow, .standstillLevel, .currentReached);

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata; errSeen = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic waitOn(input int sel, input logic v, input int lim);
    curCyc = 0;
    do begin
      @(posedge ref_clk); #1;
      curCyc++;
    end while (obs[sel] !== v && curCyc < lim);
    check(obs[sel], v);
  endtask : waitOn

  // Run the motor, stop it and follow one braking cycle to its end
  task automatic brake(input int runCyc);
    int onCyc;
    @(posedge ref_clk); runCmd <= 1'b1;
    cyc(runCyc); runCmd <= 1'b0;
    cyc(4); #1;
    check({interlockClosed, brakeRelayClosed}, {!startContactWired, 1'b0});
    waitOn(0, 1'b1, 60);
    check(starContactorClosed, 1'b1);
    waitOn(1, 1'b1, 10);
    check(curCyc, 3);
    waitOn(1, 1'b0, 130);
    onCyc = curCyc;
    waitOn(0, 1'b0, 10);
    cyc(8);
    curCyc = onCyc;
  endtask : brake

  task automatic status(input logic [5:0] exp);
    apb(1'b0, 12'h004, 32'h0);
    check(rd[9:4], exp);
  endtask : status

  task automatic flashes(input int n);
    int p = n * 8 + 10;
    int k = 0;
    logic prev;
    cyc(p); #1;
    prev = readyIndicator;
    repeat (p) begin
      @(posedge ref_clk); #1;
      if (readyIndicator && !prev) k++;
      prev = readyIndicator;
    end
    check(k, n);
  endtask : flashes

  // Flags that a mains loss leaves standing are passed in
  task automatic mainsCycle(input logic [5:0] left);
    @(posedge ref_clk); mainsPresent <= 1'b0;
    cyc(35); mainsPresent <= 1'b1;
    cyc(5); #1;
    check({interlockClosed, starContactorClosed, faultRelayClosed}, {2'h2, left == 6'h00});
    status(left);
  endtask : mainsCycle

  task automatic t_power();
    cyc(3); #1;
    check({interlockClosed, faultRelayClosed, readyIndicator, starContactorClosed}, 4'hE);
    cyc(40); #1;
    check(brakeRelayClosed, 1'b0);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0000_2832);
    apb(1'b0, 12'h00C, 32'h0);
    check(rd, 32'h0);
    check(errSeen, 1'b1);
  endtask : t_power

  task automatic t_setpoint();
    logic [6:0] trim [3] = '{7'h05, 7'h7F, 7'h40};
    logic [6:0] want [3] = '{7'h0A, 7'h64, 7'h40};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 12'h000, {24'h28, 1'b0, trim[i]});
      cyc(2); #1;
      check(brakeCurrentSetpoint, want[i]);
    end
    apb(1'b1, 12'h000, 32'h0000_2832);
  endtask : t_setpoint

  task automatic t_normal();
    brake(60);
    check(curCyc > 40 && curCyc < 99, 1'b1);
    #1 check({interlockClosed, starContactorClosed}, 2'h2);
    status(6'h00);
    apb(1'b1, 12'h000, 32'h0000_5A32);
    brake(60);
    check(curCyc >= 20 && curCyc < 40, 1'b1);
    apb(1'b1, 12'h000, 32'h0000_2832);
    startContactWired <= 1'b1;
    brake(60);
    startContactWired <= 1'b0;
  endtask : t_normal

  task automatic t_restart();
    remHold <= 8'hC8;
    @(posedge ref_clk); runCmd <= 1'b1;
    cyc(60); runCmd <= 1'b0;
    cyc(10); runCmd <= 1'b1;
    cyc(40); #1;
    check(brakeRelayClosed, 1'b0);
    apb(1'b0, 12'h004, 32'h0);
    check(rd[3:0], 4'h2);
    remHold <= 8'h0F;
  endtask : t_restart

  task automatic t_faults();
    thirdPhaseConnected <= 1'b0; stopRate <= 7'h1E;
    brake(60);
    check(curCyc >= 99, 1'b1);
    status(6'h11);
    check(faultRelayClosed, 1'b0);
    flashes(1);
    @(posedge ref_clk); runCmd <= 1'b1; thirdPhaseConnected <= 1'b1; stopRate <= 7'h02;
    cyc(5); #1;
    check(faultRelayClosed, 1'b1);
    status(6'h10);
    goodCurrent <= 1'b0;
    brake(60);
    status(6'h02);
    flashes(2);
    goodCurrent <= 1'b1;
  endtask : t_faults

  task automatic t_lockout();
    apb(1'b1, 12'h000, 32'h0000_1032);
    for (int i = 1; i < 4; i++) begin
      brake(60);
      check(curCyc >= 99, 1'b1);
      status(i == 3 ? 6'h09 : {i[1:0], 4'h1});
    end
    flashes(5);
    check({interlockClosed, starContactorClosed}, 2'h1);
    mainsCycle(6'h01);
    apb(1'b1, 12'h000, 32'h0000_2832);
  endtask : t_lockout

  task automatic t_freq();
    startContactWired <= 1'b1;
    brake(60);
    brake(10);
    status(6'h04);
    flashes(3);
    check(interlockClosed, 1'b0);
    mainsCycle(6'h00);
  endtask : t_freq

  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata, runCmd, startContactWired} = '0;
    {mainsPresent, thirdPhaseConnected, goodCurrent} = 3'h7;
    stopRate = 7'h02;
    remHold = 8'h0F;
    cyc(12);
    resetn <= 1'b1;
    t_power();
    t_setpoint();
    t_normal();
    t_restart();
    t_faults();
    t_lockout();
    t_freq();
    tally_and_finish();
  end

  initial begin
    cyc(20000);
    error_cnt++;
    tally_and_finish();
  end
endmodule : testbench
